//--- afst_strobe_timing.sv
`timescale 1ns/10ps
module afst_strobe_timing
  import afst_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output afst_pins_s memPins,
  input wire logic [DATA_W-1:0] ext_data_in,
  input wire logic ext_ready
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [CNT_W-1:0] fieldAt(input logic [31:0] w, input int pos);
    fieldAt = w[pos +: CNT_W];
  endfunction

  // zero is treated as one cycle so no phase collapses
  function automatic logic [CNT_W-1:0] atLeastOne(input logic [CNT_W-1:0] v);
    atLeastOne = (v == CNT_ZERO) ? CNT_ONE : v;
  endfunction

  logic [31:0] timingRegs [NUM_BANKS];
  logic [31:0] extraRegs [NUM_BANKS];
  logic [NUM_BANKS-1:0] readyWaitEnable;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic done_reg;
  logic isWrite_reg;
  logic [BANK_W-1:0] bank_reg;
  logic start;
  afst_state_e state_reg;
  logic [CNT_W-1:0] cnt_reg;
  afst_phase_s phase;
  logic [2:0] rdySync;
  logic rdyStable;
  logic busy;
  logic [BANK_W-1:0] selBank;
  logic [7:0] regOfs;
  logic lastCycle;
  logic [BANK_W-1:0] cmdBank;
  logic cmdWrite;
  afst_phase_s phase_reg;

  assign busy = (state_reg != ST_IDLE);
  assign selBank = avs_address[BANK_SHIFT +: BANK_W];
  assign regOfs = avs_address & (BANK_STRIDE - 8'h01);
  assign start = avs_write && !avs_waitrequest && regOfs == OFS_CMD && !busy;
  // one decode of the command word, shared by sequencer and pin drivers
  assign cmdBank = avs_writedata[F_CMD_BANK +: BANK_W];
  assign cmdWrite = avs_writedata[F_CMD_WRITE];

  // ----------------------------------------
  // bus slave: one-cycle wait then answer
  // ----------------------------------------
  // every access waits one cycle so read data comes from a flop
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      case (regOfs)
        OFS_TIMING: avs_readdata <= timingRegs[selBank];
        OFS_EXTRA: avs_readdata <= extraRegs[selBank];
        OFS_CONTROL: avs_readdata <= {31'h0000_0000, readyWaitEnable[selBank]};
        OFS_ADDR: avs_readdata <= {8'h00, addr_reg};
        OFS_WDATA: avs_readdata <= {16'h0000, wdata_reg};
        OFS_STATUS: avs_readdata <= {30'h0000_0000, done_reg, busy};
        OFS_RDATA: avs_readdata <= {16'h0000, rdata_reg};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // per-bank timing and control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        timingRegs[i] <= RST_TIMING;
        extraRegs[i] <= RST_EXTRA;
        readyWaitEnable[i] <= 1'b0;
      end
    end else if (avs_write && !avs_waitrequest) begin
      case (regOfs)
        OFS_TIMING: timingRegs[selBank] <= avs_writedata;
        OFS_EXTRA: extraRegs[selBank] <= avs_writedata;
        OFS_CONTROL: readyWaitEnable[selBank] <= avs_writedata[F_RDYEN];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // shared address and write data
  // ----------------------------------------
  // frozen while a cycle runs: pins must hold them through hold
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      addr_reg <= '0;
      wdata_reg <= '0;
    end else if (avs_write && !avs_waitrequest && !busy) begin
      case (regOfs)
        OFS_ADDR: addr_reg <= avs_writedata[ADDR_W-1:0];
        OFS_WDATA: wdata_reg <= avs_writedata[DATA_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // ready input synchroniser
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdySync <= 3'b000;
      rdyStable <= 1'b0;
    end else begin
      rdySync <= {rdySync[1:0], ext_ready};
      if (rdySync[1] == rdySync[2]) rdyStable <= rdySync[2];
    end
  end

  // ----------------------------------------
  // phase selection for the commanded bank
  // ----------------------------------------
  always_comb begin
    phase.preSetup = atLeastOne(fieldAt(extraRegs[cmdBank], F_PRESETUP));
    phase.preAccess = atLeastOne(fieldAt(extraRegs[cmdBank], F_PREACCESS));
    if (cmdWrite) begin
      phase.latch = atLeastOne(fieldAt(timingRegs[cmdBank], F_WSETUP));
      phase.access = atLeastOne(fieldAt(timingRegs[cmdBank], F_WACCESS));
      phase.hold = atLeastOne(fieldAt(timingRegs[cmdBank], F_WHOLD));
    end else begin
      phase.latch = atLeastOne(fieldAt(timingRegs[cmdBank], F_RSETUP));
      phase.access = atLeastOne(fieldAt(timingRegs[cmdBank], F_RACCESS));
      phase.hold = atLeastOne(fieldAt(timingRegs[cmdBank], F_RHOLD));
    end
  end

  // ----------------------------------------
  // timing snapshot
  // ----------------------------------------
  // counts frozen at start: a timing write mid-cycle cannot bend a running strobe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= '0;
    end else if (start) begin
      phase_reg <= phase;
    end
  end

  // strobe extends only while ready is low and waiting is enabled
  assign lastCycle = (cnt_reg == CNT_ONE) &&
                     (!readyWaitEnable[bank_reg] || rdyStable);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
      isWrite_reg <= 1'b0;
      bank_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            isWrite_reg <= cmdWrite;
            bank_reg <= cmdBank;
            state_reg <= ST_PRESETUP;
            cnt_reg <= phase.preSetup;
          end
        end
        ST_PRESETUP: begin
          if (cnt_reg == CNT_ONE) begin
            state_reg <= ST_LATCH;
            cnt_reg <= phase_reg.latch;
          end else cnt_reg <= cnt_reg - CNT_ONE;
        end
        ST_LATCH: begin
          if (cnt_reg == CNT_ONE) begin
            state_reg <= ST_PREACCESS;
            cnt_reg <= phase_reg.preAccess;
          end else cnt_reg <= cnt_reg - CNT_ONE;
        end
        ST_PREACCESS: begin
          if (cnt_reg == CNT_ONE) begin
            state_reg <= ST_STROBE;
            cnt_reg <= phase_reg.access;
          end else cnt_reg <= cnt_reg - CNT_ONE;
        end
        ST_STROBE: begin
          if (lastCycle) begin
            state_reg <= ST_HOLD;
            cnt_reg <= phase_reg.hold;
          end else if (cnt_reg != CNT_ONE) cnt_reg <= cnt_reg - CNT_ONE;
        end
        ST_HOLD: begin
          if (cnt_reg == CNT_ONE) state_reg <= ST_IDLE;
          else cnt_reg <= cnt_reg - CNT_ONE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // read capture and completion flag
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= '0;
    end else if (state_reg == ST_STROBE && lastCycle && !isWrite_reg) begin
      rdata_reg <= ext_data_in;
    end
  end

  // set wins over clear by starting a new command
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      done_reg <= 1'b0;
    end else if (state_reg == ST_HOLD && cnt_reg == CNT_ONE) begin
      done_reg <= 1'b1;
    end else if (start) begin
      done_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // pin drivers, all registered, all but dataOut from next state
  // ----------------------------------------
  afst_state_e nState;
  logic nWrite;
  logic [BANK_W-1:0] nBank;
  always_comb begin
    nState = state_reg;
    nWrite = isWrite_reg;
    nBank = bank_reg;
    case (state_reg)
      ST_IDLE: if (start) begin
        nState = ST_PRESETUP;
        nWrite = cmdWrite;
        nBank = cmdBank;
      end
      ST_PRESETUP: if (cnt_reg == CNT_ONE) nState = ST_LATCH;
      ST_LATCH: if (cnt_reg == CNT_ONE) nState = ST_PREACCESS;
      ST_PREACCESS: if (cnt_reg == CNT_ONE) nState = ST_STROBE;
      ST_STROBE: if (lastCycle) nState = ST_HOLD;
      ST_HOLD: if (cnt_reg == CNT_ONE) nState = ST_IDLE;
      default: nState = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      memPins.addr <= '0;
      memPins.bankSelN <= '1;
      memPins.latchN <= 1'b1;
      memPins.readN <= 1'b1;
      memPins.writeN <= 1'b1;
      memPins.dataOut <= '0;
      memPins.dataOe <= 1'b0;
    end else begin
      // address, bank and data stable from pre-setup through hold
      memPins.addr <= (nState != ST_IDLE) ? addr_reg : memPins.addr;
      memPins.bankSelN <= (nState != ST_IDLE) ?
                          ~(NUM_BANKS'(1) << nBank) : '1;
      memPins.latchN <= !(nState == ST_LATCH);
      memPins.readN <= !(nState == ST_STROBE && !nWrite);
      memPins.writeN <= !(nState == ST_STROBE && nWrite);
      memPins.dataOut <= wdata_reg;
      memPins.dataOe <= (nState != ST_IDLE) && nWrite;
    end
  end

endmodule // afst_strobe_timing

//--- afst_pkg.sv
package afst_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CNT_W = 4;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;

  // ----------------------------------------
  // register map (byte offsets, byte address = 4 x word index)
  // ----------------------------------------
  localparam logic [7:0] OFS_TIMING = 8'h00;
  localparam logic [7:0] OFS_EXTRA = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0C;
  localparam logic [7:0] OFS_WDATA = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_RDATA = 8'h1C;
  localparam logic [7:0] BANK_STRIDE = 8'h20;
  localparam int BANK_SHIFT = 5;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int F_RSETUP = 0;
  localparam int F_RACCESS = 4;
  localparam int F_RHOLD = 8;
  localparam int F_WSETUP = 12;
  localparam int F_WACCESS = 16;
  localparam int F_WHOLD = 20;
  localparam int F_PRESETUP = 0;
  localparam int F_PREACCESS = 4;
  localparam int F_RDYEN = 0;
  localparam int F_CMD_WRITE = 0;
  localparam int F_CMD_BANK = 4;
  localparam int F_ST_BUSY = 0;
  localparam int F_ST_DONE = 1;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] RST_TIMING = 32'h0011_1111;
  localparam logic [31:0] RST_EXTRA = 32'h0000_0011;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  typedef enum {
    ST_IDLE,
    ST_PRESETUP,
    ST_LATCH,
    ST_PREACCESS,
    ST_STROBE,
    ST_HOLD
  } afst_state_e;

  // per-bank timing as used by the sequencer
  typedef struct packed {
    logic [CNT_W-1:0] preSetup;
    logic [CNT_W-1:0] latch;
    logic [CNT_W-1:0] preAccess;
    logic [CNT_W-1:0] access;
    logic [CNT_W-1:0] hold;
  } afst_phase_s;

  // external memory pins
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [NUM_BANKS-1:0] bankSelN;
    logic latchN;
    logic readN;
    logic writeN;
    logic [DATA_W-1:0] dataOut;
    logic dataOe;
  } afst_pins_s;

endpackage

//--- afst_strobe_timing_sva.sv
`timescale 1ns/10ps
module afst_strobe_timing_chk
  import afst_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire afst_pins_s memPins
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // strobe ordering on the flash pins
  // ----------------------------------------
  AST_SEL_BEFORE_LATCH: assert property ($fell(memPins.latchN) |->
    $past(memPins.bankSelN) != 4'hF) else $error("latch fell without prior select");
  AST_LATCH_ALONE: assert property (!memPins.latchN |->
    memPins.readN && memPins.writeN && memPins.bankSelN != 4'hF) else $error("latch overlap");
  AST_GAP_BEFORE_STROBE: assert property ($fell(memPins.readN) || $fell(memPins.writeN) |->
    $past(memPins.latchN) && memPins.latchN) else $error("strobe without pre-access gap");
  AST_READ_FRAMED: assert property (!memPins.readN |->
    memPins.bankSelN != 4'hF && memPins.writeN && !memPins.dataOe) else $error("read framing");
  AST_READ_HOLD: assert property ($rose(memPins.readN) |->
    $stable(memPins.addr) && memPins.bankSelN != 4'hF) else $error("read hold broken");
  AST_WRITE_DRIVES: assert property (!memPins.writeN |->
    memPins.dataOe && memPins.readN && memPins.bankSelN != 4'hF) else $error("write framing");
  AST_WRITE_HOLD: assert property ($rose(memPins.writeN) |->
    memPins.dataOe && $stable(memPins.dataOut) && $stable(memPins.addr))
    else $error("write hold broken");
  AST_DESELECT_AFTER_HOLD: assert property ($rose(memPins.bankSelN == 4'hF) |->
    $past(memPins.readN) && $past(memPins.writeN)) else $error("deselect with strobe low");
endmodule // afst_strobe_timing_chk

//--- afst_flash_model.sv
`timescale 1ns/10ps
module afst_flash_model
  import afst_pkg::*;
(
  input wire logic sys_clk,
  input wire afst_pins_s memPins,
  output logic [DATA_W-1:0] ext_data_in,
  output logic ext_ready
);
  logic [DATA_W-1:0] lastData = 16'h0000;
  // stalled flash: wait disabled, so it must not stretch any strobe
  assign ext_ready = 1'b0;
  // released bus shows inverse of last value, never stale data
  assign ext_data_in = (memPins.bankSelN != 4'hF && !memPins.readN) ?
    (memPins.addr[15:0] ^ 16'hA5C3) : ~lastData;
  // remember only what was really driven, so a released bus cannot echo itself
  always @(posedge sys_clk) begin
    if (memPins.bankSelN != 4'hF && !memPins.readN) lastData <= ext_data_in;
  end
endmodule // afst_flash_model

//--- afst_strobe_timing_tb.sv
`timescale 1ns/10ps
module afst_strobe_timing_tb;
  import afst_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  afst_pins_s memPins;
  logic [DATA_W-1:0] ext_data_in;
  logic ext_ready;
  int errors = 0;
  int samples_checked = 0;
  int ph[5];
  int nCyc = 0;
  int cycles = 0;
  int idx;
  logic inCyc = 1'b0;
  logic seenL = 1'b0;
  logic seenS = 1'b0;
  logic [3:0] selSeen;
  logic [23:0] addrSeen;
  logic [15:0] dataSeen;
  logic [31:0] rd;
  always #12.5 sys_clk = ~sys_clk;
  afst_strobe_timing u_afst_strobe_timing (.sys_clk(sys_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .memPins(memPins), .ext_data_in(ext_data_in),
    .ext_ready(ext_ready));
  afst_flash_model u_afst_flash_model (.sys_clk(sys_clk), .memPins(memPins),
    .ext_data_in(ext_data_in), .ext_ready(ext_ready));
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // idle edge after release, so strobes are never re-driven in one step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  function automatic int fld(input logic [3:0] v);
    return (v == 4'h0) ? 1 : int'(v);
  endfunction
  // ----------------------------------------
  // pin phase monitor and timeout
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
    if (memPins.bankSelN === 4'hF) begin
      seenL = 0;
      seenS = 0;
      inCyc = 0;
    end else begin
      if (!inCyc) nCyc++;
      inCyc = 1;
      if (!memPins.latchN) seenL = 1;
      if (!memPins.readN || !memPins.writeN) seenS = 1;
      idx = !memPins.latchN ? 1 : (!memPins.readN || !memPins.writeN) ? 3 : seenS ? 4 :
        seenL ? 2 : 0;
      ph[idx]++;
      if (idx == 3) begin
        selSeen = memPins.bankSelN;
        addrSeen = memPins.addr;
        dataSeen = memPins.dataOut;
      end
    end
  end
  task automatic op(input int b, input logic wr, input logic [31:0] tim, input logic [7:0] ext,
                    input logic [23:0] adr, input logic [15:0] wd);
    logic [7:0] base;
    int exp[5];
    int n0;
    base = 8'(b * 32);
    exp = '{fld(ext[3:0]), fld(wr ? tim[F_WSETUP +: 4] : tim[F_RSETUP +: 4]), fld(ext[7:4]),
      fld(wr ? tim[F_WACCESS +: 4] : tim[F_RACCESS +: 4]),
      fld(wr ? tim[F_WHOLD +: 4] : tim[F_RHOLD +: 4])};
    bus(1, base + OFS_TIMING, tim);
    bus(1, base + OFS_EXTRA, {24'h0, ext});
    bus(1, OFS_ADDR, {8'h0, adr});
    bus(1, OFS_WDATA, {16'h0, wd});
    ph = '{default: 0};
    n0 = nCyc;
    bus(1, OFS_CMD, {26'h0, 2'(b), 3'h0, wr});
    // second command lands while busy and must be dropped
    bus(1, OFS_CMD, {26'h0, 2'(b), 3'h0, wr});
    for (int i = 0; i < 200; i++) begin
      bus(0, OFS_STATUS, 32'h0);
      if (rd[F_ST_BUSY] === 1'b0) break;
    end
    check(32'(rd[F_ST_DONE]), 32'h1);
    check(32'(nCyc - n0), 32'h1);
    for (int i = 0; i < 5; i++) check(32'(ph[i]), 32'(exp[i]));
    check({28'h0, selSeen}, {28'h0, ~(4'h1 << b)});
    check({8'h0, addrSeen}, {8'h0, adr});
    if (wr) check({16'h0, dataSeen}, {16'h0, wd});
    else begin
      bus(0, OFS_RDATA, 32'h0);
      check(rd, {16'h0, adr[15:0] ^ 16'hA5C3});
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    bus(0, OFS_TIMING, 32'h0);
    check(rd, RST_TIMING);
    bus(0, 8'h40 + OFS_EXTRA, 32'h0);
    check(rd, RST_EXTRA);
    bus(0, 8'h60 + OFS_CONTROL, 32'h0);
    check(rd, 32'h0);
    bus(1, 8'h60 + OFS_CONTROL, 32'h1);
    bus(0, 8'h60 + OFS_CONTROL, 32'h0);
    check(rd, 32'h1);
    bus(1, 8'h60 + OFS_CONTROL, 32'h0);
    bus(0, 8'h60 + OFS_CONTROL, 32'h0);
    check(rd, 32'h0);
    op(1, 1'b0, 32'h0000_0243, 8'h32, 24'h12_3456, 16'h0000);
    op(2, 1'b1, 32'h0035_2000, 8'h21, 24'hAB_CDEF, 16'h5A3C);
    op(3, 1'b0, 32'h0000_0000, 8'h00, 24'hFF_FFFF, 16'h0000);
    op(0, 1'b1, RST_TIMING, RST_EXTRA[7:0], 24'h00_0001, 16'hFFFF);
    op(1, 1'b0, 32'h0000_0FFF, 8'hFF, 24'h00_8001, 16'h0000);
    op(3, 1'b1, 32'h00FF_F000, 8'hFF, 24'h80_0000, 16'h0001);
    conclude();
  end
endmodule // afst_strobe_timing_tb
bind afst_strobe_timing afst_strobe_timing_chk u_afst_strobe_timing_chk (.sys_clk(sys_clk),
  .resetn(resetn), .memPins(memPins));
